// file: inc/fwp_pkg.sv
// Package: register map, field layout, timing counts and state types of the flash word programmer
package fwp_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses (one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] FWP_OFS_CTRL = 8'h00;
   localparam logic [7:0] FWP_OFS_WDATA = 8'h04;
   localparam logic [7:0] FWP_OFS_ADDRH = 8'h08;
   localparam logic [7:0] FWP_OFS_ADDRL = 8'h0C;
   localparam logic [7:0] FWP_OFS_STAT = 8'h10;

   // ----------------------------------------------------------------
   // Field positions of the control register and the page field of the high address register
   // ----------------------------------------------------------------
   localparam int FWP_BIT_ERASE = 0;
   localparam int FWP_BIT_WRITE = 1;
   localparam int FWP_BIT_CONTRD = 4;
   localparam int FWP_BIT_SWBUSY = 6;
   localparam int FWP_BIT_BUSY = 7;
   localparam int FWP_PAGE_LSB = 1;
   localparam int FWP_PAGE_MSB = 5;

   // ----------------------------------------------------------------
   // Geometry, reset values and the DMA trigger number
   // ----------------------------------------------------------------
   localparam int FWP_PAGE_BYTES = 1024;
   localparam int FWP_PAGE_WORDS = 512;
   localparam int FWP_ADDR_W = 14;
   localparam int FWP_PAGE_W = 5;
   localparam logic [5:0] FWP_RST_ADDRH = 6'h00;
   localparam logic [7:0] FWP_RST_ADDRL = 8'h00;
   localparam logic [7:0] FWP_RST_WDATA = 8'h00;
   localparam logic [4:0] FWP_DMA_DMA_TRIGGER_SELECT_SEL = 5'h12;

   // ----------------------------------------------------------------
   // Timing: figures in ns, counts in cycles of the 25 MHz clock
   // ----------------------------------------------------------------
   localparam int FWP_CLK_PERIOD_NS = 40;
   localparam int FWP_T_WORD_NS = 20000;
   localparam int FWP_T_TMO_NS = 40000;
   localparam longint FWP_T_PAGE_NS = 20000000;
   localparam longint FWP_T_CHIP_NS = 200000000;
   localparam int FWP_WORD_CYC = FWP_T_WORD_NS / FWP_CLK_PERIOD_NS;
   localparam int FWP_TMO_CYC = FWP_T_TMO_NS / FWP_CLK_PERIOD_NS;
   localparam int FWP_PAGE_CYC = int'(FWP_T_PAGE_NS / FWP_CLK_PERIOD_NS);
   localparam int FWP_CHIP_CYC = int'(FWP_T_CHIP_NS / FWP_CLK_PERIOD_NS);
   localparam int FWP_CNT_W = 24;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {FWP_IDLE, FWP_ERASE, FWP_WAIT, FWP_PROG, FWP_CHIP} fwp_state_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [FWP_ADDR_W-1:0] addr;
      logic [15:0] data;
   } fwp_arr_cmd_t;

endpackage : fwp_pkg

// file: rtl/fwp_sync.sv
// Three-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
`default_nettype none
module fwp_sync
   import fwp_pkg::*;
(
   input wire logic clock_i, // System clock
   input wire logic nrst_i, // Async reset, active low
   input wire logic async_i, // Level from outside the domain
   output logic sync_o // Level, changes once stages two and three agree
);
   typedef struct packed {
      logic [2:0] stage;
      logic level;
   } fwp_sync_st_t;

   fwp_sync_st_t st_reg;
   fwp_sync_st_t st_next;

   // ----------------------------------------------------------------
   // Next state: stage 0 only feeds stage 1
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.stage = {st_reg.stage[1:0], async_i};
      if (st_reg.stage[1] == st_reg.stage[2])
      begin
         st_next.level = st_reg.stage[2];
      end
   end

   // Register the state
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign sync_o = st_reg.level;
endmodule : fwp_sync
`default_nettype wire

// file: rtl/fwp_timer.sv
// Load-and-count-down timer with a one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none
module fwp_timer
   import fwp_pkg::*;
#(
   parameter int W = FWP_CNT_W
)
(
   input wire logic clock_i, // System clock
   input wire logic nrst_i, // Async reset, active low
   input wire logic load_i, // Pulse: start counting
   input wire logic stop_i, // Pulse: abandon count
   input wire logic [W-1:0] count_i, // Cycles until done
   output logic run_o, // High while counting
   output logic done_o // Pulse when count ends
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic run;
      logic done;
   } fwp_tmr_st_t;

   fwp_tmr_st_t st_reg;
   fwp_tmr_st_t st_next;

   // Load wins over stop so a restart never gets lost
   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (load_i)
      begin
         st_next.cnt = count_i;
         st_next.run = 1'b1;
      end
      else if (stop_i)
      begin
         st_next.run = 1'b0;
      end
      else if (st_reg.run)
      begin
         if (st_reg.cnt <= W'(1))
         begin
            st_next.run = 1'b0;
            st_next.done = 1'b1;
         end
         else
         begin
            st_next.cnt = st_reg.cnt - W'(1);
         end
      end
   end

   // Register the state
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign run_o = st_reg.run;
   assign done_o = st_reg.done;
endmodule : fwp_timer
`default_nettype wire

// file: rtl/fwp_ctrl.sv
// Flash word program controller: AXI4-Lite registers, byte pairing, sequencer
// What this block does
// - Flash is 8/16/32 pages of 1024 bytes
// - Program whole 16-bit words only
// - Word address is high then low registers
// - High bits 5:1 page; rest picks 512 words
// - Program consecutive words, advancing the address
// - Programming only clears bits, never sets
// - Only erase returns bits to one
// - Word busy high during each word program
// - First byte after boundary is low byte
// - Second byte starts a word program
// - Word 20 us, page 20 ms, chip 200 ms
// - Deny CPU flash reads while word programs
// - Flash access during word busy is violation
// - CPU is never stalled by starting write
// - DMA trigger whenever data port is ready for a byte
// - Setting program command gives first DMA trigger
// - Bytes late over 40 us abort the operation
// - Abort keeps the failing word address
// - Restart resumes at the held address
// - Busy bit 7 reads one during operations
// - Erase page first when erase and program together
`timescale 1ns/100ps
`default_nettype none
module fwp_ctrl
   import fwp_pkg::*;
#(
   parameter int PAGES = 32, // 8, 16 or 32
   parameter int WORD_CYC = FWP_WORD_CYC,
   parameter int TMO_CYC = FWP_TMO_CYC,
   parameter int PAGE_CYC = FWP_PAGE_CYC, // Shorten for simulation
   parameter int CHIP_CYC = FWP_CHIP_CYC // Shorten for simulation
)
(
   input wire logic clock_i, // System clock 25 MHz
   input wire logic nrst_i, // Async reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic chip_erase_i, // Debug-port chip erase level, async
   input wire logic cpu_flash_rd_i, // CPU wants a flash read or fetch
   output logic cpu_flash_gnt_o, // Read allowed this cycle
   output logic access_viol_o, // Pulse: flash access while word busy
   input wire logic [4:0] dma_trigger_select_i, // Trigger selected by armed DMA channel
   output logic dma_dma_trigger_select_o, // Pulse: write data port ready
   output fwp_arr_cmd_t arr_cmd_o, // Command to flash array
   input wire logic [15:0] arr_rdata_i, // Stored word at arr_cmd_o.addr
   output logic [FWP_PAGE_W-1:0] erase_page_o, // Page under erase
   output logic erase_o, // Page erase in progress
   output logic chip_erase_o // Chip erase in progress
);
   typedef struct packed {
      fwp_state_t state;
      logic [5:0] addr_h;
      logic [7:0] addr_l;
      logic [7:0] wdata;
      logic [7:0] low_byte;
      logic have_low;
      logic pend_write;
      logic contrd;
      logic viol_sticky;
      logic dma_trigger_select;
      logic viol;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] bresp;
      fwp_arr_cmd_t cmd;
   } fwp_ctrl_st_t;

   fwp_ctrl_st_t st_reg;
   fwp_ctrl_st_t st_next;
   logic chip_req;
   logic wtmr_load, wtmr_run, wtmr_done;
   logic otmr_load, otmr_run, otmr_done;
   logic tmo_load, tmo_stop, tmo_done;
   logic [FWP_CNT_W-1:0] otmr_count;
   logic wr_go, rd_go, byte_wr;
   logic [FWP_ADDR_W-1:0] word_addr;
   logic [7:0] ctrl_rd;

   // ----------------------------------------------------------------
   // Helpers: chip erase synchroniser and three timers
   // ----------------------------------------------------------------
   fwp_sync u_chip_sync (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .async_i(chip_erase_i),
      .sync_o(chip_req)
   );

   // Word program time
   fwp_timer u_word_tmr (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .load_i(wtmr_load),
      .stop_i(1'b0),
      .count_i(FWP_CNT_W'(WORD_CYC)),
      .run_o(wtmr_run),
      .done_o(wtmr_done)
   );

   // Page or chip erase time
   fwp_timer u_erase_tmr (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .load_i(otmr_load),
      .stop_i(1'b0),
      .count_i(otmr_count),
      .run_o(otmr_run),
      .done_o(otmr_done)
   );

   // Byte arrival watchdog
   fwp_timer u_tmo_tmr (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .load_i(tmo_load),
      .stop_i(tmo_stop),
      .count_i(FWP_CNT_W'(TMO_CYC)),
      .run_o(),
      .done_o(tmo_done)
   );

   // ----------------------------------------------------------------
   // Bus decode: a write needs both channels; one of each at a time
   // ----------------------------------------------------------------
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
   assign rd_go = s_axi_arvalid && !st_reg.rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign byte_wr = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == FWP_OFS_WDATA);

   // Word address is high then low page in high bits 5:1
   assign word_addr = {st_reg.addr_h, st_reg.addr_l};
   assign erase_page_o = st_reg.addr_h[FWP_PAGE_MSB:FWP_PAGE_LSB]; // 512-word pages
   assign erase_o = (st_reg.state == FWP_ERASE); // Erase returns cells to ones
   assign chip_erase_o = (st_reg.state == FWP_CHIP);
   assign arr_cmd_o = st_reg.cmd;
   assign dma_dma_trigger_select_o = st_reg.dma_trigger_select;
   assign access_viol_o = st_reg.viol;
   // No read reaches the array while a word programs
   assign cpu_flash_gnt_o = cpu_flash_rd_i && !wtmr_run && (st_reg.state != FWP_ERASE)
                            && (st_reg.state != FWP_CHIP);

   // Control register image: busy bit 7 word busy bit 6
   always_comb
   begin
      ctrl_rd = 8'h00;
      ctrl_rd[FWP_BIT_BUSY] = (st_reg.state != FWP_IDLE);
      ctrl_rd[FWP_BIT_SWBUSY] = wtmr_run;
      ctrl_rd[FWP_BIT_CONTRD] = st_reg.contrd;
   end

   // ----------------------------------------------------------------
   // Main next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.dma_trigger_select = 1'b0;
      st_next.viol = 1'b0;
      st_next.cmd.req = 1'b0;
      wtmr_load = 1'b0;
      otmr_load = 1'b0;
      otmr_count = FWP_CNT_W'(PAGE_CYC);
      tmo_load = 1'b0;
      tmo_stop = 1'b0;

      // Reads answer one cycle after the address is taken
      if (st_reg.rvalid && s_axi_rready)
         st_next.rvalid = 1'b0;
      if (rd_go)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp = 2'b00;
         st_next.rdata = 32'h0000_0000;
         unique case (s_axi_araddr)
            FWP_OFS_CTRL: st_next.rdata[7:0] = ctrl_rd;
            FWP_OFS_WDATA: st_next.rdata[7:0] = st_reg.wdata;
            FWP_OFS_ADDRH: st_next.rdata[5:0] = st_reg.addr_h;
            FWP_OFS_ADDRL: st_next.rdata[7:0] = st_reg.addr_l;
            FWP_OFS_STAT: st_next.rdata[0] = st_reg.viol_sticky;
            default: st_next.rresp = 2'b10;
         endcase
      end

      // Flash read while word busy counts as violation
      if (cpu_flash_rd_i && wtmr_run)
      begin
         st_next.viol = 1'b1;
         st_next.viol_sticky = 1'b1;
      end

      // Writes answer one cycle after both channels are taken; never stall
      if (st_reg.bvalid && s_axi_bready)
         st_next.bvalid = 1'b0;
      if (wr_go)
      begin
         st_next.bvalid = 1'b1;
         st_next.bresp = 2'b00;
         unique case (s_axi_awaddr)
            FWP_OFS_CTRL:
            begin
               if (s_axi_wstrb[0])
               begin
                  st_next.contrd = s_axi_wdata[FWP_BIT_CONTRD];
                  if (st_reg.state == FWP_IDLE && s_axi_wdata[FWP_BIT_ERASE])
                  begin
                     // Erase goes first, program waits for it
                     st_next.state = FWP_ERASE;
                     st_next.pend_write = s_axi_wdata[FWP_BIT_WRITE];
                     otmr_load = 1'b1;
                  end
                  else if (st_reg.state == FWP_IDLE && s_axi_wdata[FWP_BIT_WRITE])
                  begin
                     st_next.state = FWP_WAIT; // Address kept, so a restart resumes
                     st_next.have_low = 1'b0;
                     tmo_load = 1'b1;
                     // First trigger from the command itself
                     st_next.dma_trigger_select = (dma_trigger_select_i == FWP_DMA_DMA_TRIGGER_SELECT_SEL);
                  end
               end
            end
            FWP_OFS_WDATA:
            begin
               if (s_axi_wstrb[0])
                  st_next.wdata = s_axi_wdata[7:0];
            end
            FWP_OFS_ADDRH:
            begin
               if (s_axi_wstrb[0] && st_reg.state == FWP_IDLE)
                  st_next.addr_h = s_axi_wdata[5:0];
            end
            FWP_OFS_ADDRL:
            begin
               if (s_axi_wstrb[0] && st_reg.state == FWP_IDLE)
                  st_next.addr_l = s_axi_wdata[7:0];
            end
            FWP_OFS_STAT:
            begin
               // Write one to clear; a new violation this cycle wins
               if (s_axi_wstrb[0] && s_axi_wdata[0] && !(cpu_flash_rd_i && wtmr_run))
                  st_next.viol_sticky = 1'b0;
            end
            default: st_next.bresp = 2'b10;
         endcase
      end

      // Sequencer
      unique case (st_reg.state)
         FWP_IDLE:
         begin
            if (chip_req)
            begin
               st_next.state = FWP_CHIP;
               otmr_load = 1'b1;
               otmr_count = FWP_CNT_W'(CHIP_CYC);
            end
         end
         FWP_ERASE, FWP_CHIP:
         begin
            if (otmr_done)
            begin
               if (st_reg.state == FWP_ERASE && st_reg.pend_write)
               begin
                  st_next.state = FWP_WAIT;
                  st_next.have_low = 1'b0;
                  tmo_load = 1'b1;
                  st_next.dma_trigger_select = (dma_trigger_select_i == FWP_DMA_DMA_TRIGGER_SELECT_SEL);
               end
               else
                  st_next.state = FWP_IDLE;
               st_next.pend_write = 1'b0;
            end
         end
         FWP_WAIT:
         begin
            if (byte_wr && !st_reg.have_low)
            begin
               st_next.low_byte = s_axi_wdata[7:0];
               st_next.have_low = 1'b1;
               st_next.dma_trigger_select = (dma_trigger_select_i == FWP_DMA_DMA_TRIGGER_SELECT_SEL);
            end
            else if (byte_wr)
            begin
               // Second byte starts one word program
               st_next.have_low = 1'b0;
               st_next.state = FWP_PROG;
               wtmr_load = 1'b1;
               tmo_stop = 1'b1;
               st_next.cmd.req = 1'b1;
               st_next.cmd.we = 1'b1;
               st_next.cmd.addr = word_addr;
               // Only clears bits: stored zeros stay zero
               st_next.cmd.data = arr_rdata_i & {s_axi_wdata[7:0], st_reg.low_byte};
            end
            else if (tmo_done)
            begin
               // Late bytes abort; address stays at failing word
               st_next.state = FWP_IDLE;
               st_next.have_low = 1'b0;
            end
         end
         FWP_PROG:
         begin
            if (wtmr_done)
            begin
               // Advance to next word and reopen the port
               {st_next.addr_h, st_next.addr_l} = word_addr + FWP_ADDR_W'(1);
               st_next.state = FWP_WAIT;
               tmo_load = 1'b1;
               st_next.dma_trigger_select = (dma_trigger_select_i == FWP_DMA_DMA_TRIGGER_SELECT_SEL);
            end
         end
         default: st_next.state = FWP_IDLE;
      endcase
      st_next.cmd.addr = {st_next.addr_h, st_next.addr_l}; // Read-back word is the one to program
   end

   // Register the state
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_reg <= '0;
         st_reg.state <= FWP_IDLE;
         st_reg.addr_h <= FWP_RST_ADDRH;
         st_reg.addr_l <= FWP_RST_ADDRL;
         st_reg.wdata <= FWP_RST_WDATA;
      end
      else
         st_reg <= st_next;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_busy_bit;
      @(posedge clock_i) disable iff (!nrst_i)
      (st_reg.state != FWP_IDLE) |-> ctrl_rd[FWP_BIT_BUSY];
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit low in operation");

   property p_word_busy;
      @(posedge clock_i) disable iff (!nrst_i)
      wtmr_load |=> ctrl_rd[FWP_BIT_SWBUSY] [*8];
   endproperty
   a_word_busy: assert property (p_word_busy) else $error("word busy dropped early");

   property p_no_read;
      @(posedge clock_i) disable iff (!nrst_i)
      wtmr_run |-> !cpu_flash_gnt_o;
   endproperty
   a_no_read: assert property (p_no_read) else $error("flash read granted while busy");

   property p_viol;
      @(posedge clock_i) disable iff (!nrst_i)
      (cpu_flash_rd_i && wtmr_run) |=> access_viol_o;
   endproperty
   a_viol: assert property (p_viol) else $error("violation not flagged");

   property p_clear_only;
      @(posedge clock_i) disable iff (!nrst_i)
      st_next.cmd.req |-> ((st_next.cmd.data & ~arr_rdata_i) == 16'h0000);
   endproperty
   a_clear_only: assert property (p_clear_only) else $error("program sets a bit");

   property p_low_first;
      @(posedge clock_i) disable iff (!nrst_i)
      (byte_wr && st_reg.state == FWP_WAIT && st_reg.have_low) |=>
         (arr_cmd_o.data[7:0] == ($past(st_reg.low_byte) & $past(arr_rdata_i[7:0])));
   endproperty
   a_low_first: assert property (p_low_first) else $error("low byte misplaced");

   property p_advance;
      @(posedge clock_i) disable iff (!nrst_i)
      (st_reg.state == FWP_PROG && wtmr_done) |=> (word_addr == $past(word_addr) + 14'h0001);
   endproperty
   a_advance: assert property (p_advance) else $error("address did not advance");

   property p_abort_keep;
      @(posedge clock_i) disable iff (!nrst_i)
      (st_reg.state == FWP_WAIT && tmo_done && !byte_wr) |=>
         (st_reg.state == FWP_IDLE && word_addr == $past(word_addr) && !st_reg.have_low);
   endproperty
   a_abort_keep: assert property (p_abort_keep) else $error("abort lost address");

   property p_second_byte;
      @(posedge clock_i) disable iff (!nrst_i)
      (byte_wr && st_reg.state == FWP_WAIT && st_reg.have_low) |=>
         (arr_cmd_o.req && ctrl_rd[FWP_BIT_SWBUSY]);
   endproperty
   a_second_byte: assert property (p_second_byte) else $error("second byte no program");

   c_word: cover property (@(posedge clock_i) disable iff (!nrst_i) wtmr_done);
   c_abort: cover property (@(posedge clock_i) disable iff (!nrst_i)
      (st_reg.state == FWP_WAIT && tmo_done));
   c_erase_prog: cover property (@(posedge clock_i) disable iff (!nrst_i)
      (st_reg.state == FWP_ERASE && otmr_done && st_reg.pend_write));
endmodule : fwp_ctrl
`default_nettype wire

// file: testbench/fwp_flash_model.sv
// Behavioural flash array facing the word program controller
`timescale 1ns/100ps
`default_nettype none
module fwp_flash_model
   import fwp_pkg::*;
(
   input wire logic clock_i, // System clock
   input wire fwp_arr_cmd_t cmd_i, // Command from controller
   input wire logic [FWP_PAGE_W-1:0] page_i, // Page under erase
   input wire logic erase_i, // Page erase level
   input wire logic chip_i, // Chip erase level
   output logic [15:0] rdata_o // Stored word at command address
);
   logic [15:0] mem [0:16383];
   logic [13:0] last_addr;
   logic [15:0] last_data;
   // Cells start erased; like real cells a write can only pull bits low
   initial foreach (mem[i]) mem[i] = 16'hFFFF;
   always @(posedge clock_i)
   begin
      if (cmd_i.req && cmd_i.we)
      begin
         mem[cmd_i.addr] <= mem[cmd_i.addr] & cmd_i.data;
         last_addr <= cmd_i.addr;
         last_data <= cmd_i.data;
      end
      if (erase_i || chip_i)
         for (int i = 0; i < 16384; i++)
            if (chip_i || i[13:9] == page_i) mem[i] <= 16'hFFFF;
   end
   assign rdata_o = mem[cmd_i.addr];
endmodule : fwp_flash_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the flash word program controller
`timescale 1ns/100ps
`default_nettype none
module testbench
   import fwp_pkg::*;
;
   logic clock_i = 0, nrst_i = 0, awv = 0, wv = 0, arv = 0, rd_i = 0, bry = 0, rry = 0, cei = 0;
   logic [4:0] tsel = FWP_DMA_DMA_TRIGGER_SELECT_SEL;
   logic awr, wr_y, arr, bv, rv, gnt, viol, dma_trigger_select, er, cer;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, d;
   logic [1:0] br, rr, r;
   logic [4:0] pg;
   logic [15:0] ard;
   fwp_arr_cmd_t cmd;
   int num_errors = 0, check_count = 0, dma_trigger_select_cnt = 0;
   always #20 clock_i = ~clock_i;
   // Short counts keep the run brief
   fwp_ctrl #(.WORD_CYC(20), .TMO_CYC(40), .PAGE_CYC(50), .CHIP_CYC(50)) fwp_ctrl_inst
   (
      .clock_i(clock_i), .nrst_i(nrst_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr_y), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .chip_erase_i(cei),
      .cpu_flash_rd_i(rd_i), .cpu_flash_gnt_o(gnt), .access_viol_o(viol),
      .dma_trigger_select_i(tsel), .dma_dma_trigger_select_o(dma_trigger_select), .arr_cmd_o(cmd),
      .arr_rdata_i(ard), .erase_page_o(pg), .erase_o(er), .chip_erase_o(cer)
   );
   fwp_flash_model fwp_flash_model_inst
   (
      .clock_i(clock_i), .cmd_i(cmd), .page_i(pg), .erase_i(er), .chip_i(cer), .rdata_o(ard)
   );
   always @(posedge clock_i) if (dma_trigger_select === 1'b1) dma_trigger_select_cnt++;
   // ----------------------------------------------------------------
   // Bus tasks and checks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b0;
      // Response ready comes late so the response must stand a cycle
      do
      begin
         @(posedge clock_i);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_y) wv <= 1'b0;
         if (bv === 1'b1 && !bry) bry <= 1'b1;
      end
      while (!(bv === 1'b1 && bry === 1'b1));
   endtask : wr
   task automatic rd(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b0;
      do
      begin
         @(posedge clock_i);
         if (arv && arr) arv <= 1'b0;
         if (rv === 1'b1 && !rry) rry <= 1'b1;
      end
      while (!(rv === 1'b1 && rry === 1'b1));
      d = rdat;
      r = rr;
   endtask : rd
   // Polls control until the masked busy bits are low
   task automatic wt(input logic [7:0] m);
      do rd(FWP_OFS_CTRL);
      while ((d[7:0] & m) != 8'h00);
   endtask : wt
   task automatic bp(input logic [7:0] lo, input logic [7:0] hi);
      wr(FWP_OFS_WDATA, 32'(lo));
      wr(FWP_OFS_WDATA, 32'(hi));
   endtask : bp
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      rd(FWP_OFS_CTRL);
      chk(d, 32'h0);
      rd(8'h1C);
      chk(32'(r), 32'h2);
      wr(FWP_OFS_ADDRH, 32'h05);
      wr(FWP_OFS_ADDRL, 32'hFF);
      wr(FWP_OFS_CTRL, 32'h02);
      repeat (2) @(posedge clock_i);
      chk(32'(dma_trigger_select_cnt), 32'h1);
      bp(8'h34, 8'h12);
      rd_i <= 1'b1;
      @(posedge clock_i);
      chk(32'(gnt), 32'h0);
      rd_i <= 1'b0;
      rd(FWP_OFS_CTRL);
      chk(d, 32'hC0);
      rd(FWP_OFS_STAT);
      chk(d, 32'h1);
      chk(32'(fwp_flash_model_inst.last_addr), 32'h05FF);
      chk(32'(fwp_flash_model_inst.last_data), 32'h1234);
      wt(8'h40);
      repeat (2) @(posedge clock_i);
      chk(32'(dma_trigger_select_cnt), 32'h3);
      $display("word program test done");
      // A lone byte then silence must abort and drop the half pair; other trigger stays silent
      tsel <= 5'h00;
      wr(FWP_OFS_WDATA, 32'hAA);
      chk(32'(dma_trigger_select_cnt), 32'h3);
      tsel <= FWP_DMA_DMA_TRIGGER_SELECT_SEL;
      wt(8'h80);
      rd(FWP_OFS_ADDRH);
      chk(d, 32'h06);
      wr(FWP_OFS_CTRL, 32'h02);
      bp(8'h00, 8'hFF);
      chk(32'(fwp_flash_model_inst.last_addr), 32'h0600);
      chk(32'(fwp_flash_model_inst.last_data), 32'hFF00);
      wt(8'h80);
      wr(FWP_OFS_ADDRL, 32'h00);
      wr(FWP_OFS_CTRL, 32'h02);
      bp(8'hFF, 8'h0F);
      chk(32'(fwp_flash_model_inst.last_data), 32'h0F00);
      wt(8'h80);
      $display("abort and resume test done");
      wr(FWP_OFS_CTRL, 32'h01);
      wt(8'h80);
      chk(32'(fwp_flash_model_inst.mem[14'h0600]), 32'hFFFF);
      $display("erase test done");
      // Debug chip erase passes the synchroniser, then clears every page
      cei <= 1'b1;
      repeat (6) @(posedge clock_i);
      cei <= 1'b0;
      @(posedge clock_i);
      chk(32'(cer), 32'h1);
      wt(8'h80);
      chk(32'(fwp_flash_model_inst.mem[14'h05FF]), 32'hFFFF);
      rd_i <= 1'b1;
      @(posedge clock_i);
      chk(32'(gnt), 32'h1);
      rd_i <= 1'b0;
      $display("chip erase test done");
      test_done();
   end
   initial
   begin
      #800000;
      num_errors++;
      test_done();
   end
endmodule : testbench
`default_nettype wire
